// *** display_seq_pkg.sv ***
// Constants for the display channel sequencer: strobe codes, latch bit
// positions, reset values and timing.
// Assumes a 100 MHz clock_in.
`default_nettype none
package display_seq_pkg;
   localparam int CLOCK_HZ = 100_000_000;
   localparam int CLOCK_NS = 10;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int NUM_STROBES = 8;
   localparam int NUM_SELECTS = 5;
   localparam int SWITCH_INPUTS = 4;
   // Nominal processor write pulse; the strobes simply follow it
   localparam int WRITE_PULSE_NS = 700;
   localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
   // Strobe codes on the three address lines
   localparam logic [2:0] STROBE_CONTROL = 3'h0;
   localparam logic [2:0] STROBE_TEST = 3'h1;
   localparam logic [2:0] READ_STATUS = 3'h2;
   // Display control latch
   localparam int CTRL_DRIVE_ALT_BIT = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Display test latch
   localparam int TEST_SCAN_CLK_BIT = 0;
   localparam int TEST_SCAN_MODE_BIT = 1;
   localparam int TEST_SPEAKER_BIT = 2;
   localparam int TEST_LED_MODE_BIT = 3;
   localparam int TEST_GREEN_BIT = 4;
   localparam int TEST_RED_BIT = 5;
   localparam logic [7:0] TEST_RESET = 8'h30;
   // Status word
   localparam int STAT_READBACK_BIT = 5;
   localparam int STAT_INIT_BIT = 6;
   // Tone
   localparam int TONE_HZ = 4000;
   localparam int TONE_HALF_CYCLES = CLOCK_HZ / (2 * TONE_HZ);
endpackage : display_seq_pkg
`default_nettype wire

// *** chan_switch.sv ***
// Four-input channel switch with active-low one-of-four selects.
// Assumes the selects and data are synchronous to clock_in.
`default_nettype none
module chan_switch
   import display_seq_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic enable_in,
   // Signal inputs
   input wire logic [WIDTH-1:0] in_a_in,
   input wire logic [WIDTH-1:0] in_b_in,
   input wire logic [WIDTH-1:0] in_c_in,
   input wire logic [WIDTH-1:0] in_d_in,
   input wire logic [SWITCH_INPUTS-1:0] select_n_in,
   // Output
   output logic [WIDTH-1:0] out_out
);
   wire logic [SWITCH_INPUTS-1:0] pick = ~select_n_in;
   // No select or a clash gives a blank output rather than a sum
   wire logic [WIDTH-1:0] next_out =
      (pick == 4'h1) ? in_a_in :
      (pick == 4'h2) ? in_b_in :
      (pick == 4'h4) ? in_c_in :
      (pick == 4'h8) ? in_d_in : '0;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         out_out <= '0;
      end else if (enable_in) begin
         out_out <= next_out;
      end
   end
endmodule : chan_switch
`default_nettype wire

// *** tone_gen.sv ***
// Free-running square tone, held stopped while not running.
// Assumes run_in is synchronous to clock_in.
`default_nettype none
module tone_gen
   import display_seq_pkg::*;
#(
   parameter int HALF_CYCLES = TONE_HALF_CYCLES
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic enable_in,
   // Control and tone
   input wire logic run_in,
   output logic tone_out
);
   localparam int CW = $clog2(HALF_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
   logic [CW-1:0] count;
   wire logic wrap = (count == LAST);

   always_ff @(posedge clock_in) begin
      if (!nrst_in || (enable_in && !run_in)) begin
         count <= '0;
         tone_out <= 1'b0;
      end else if (enable_in) begin
         count <= wrap ? '0 : count + 1'b1;
         tone_out <= wrap ? ~tone_out : tone_out;
      end
   end
endmodule : tone_gen
`default_nettype wire

// *** display_channel_sequencer.sv ***
// Display channel sequencer: write strobe decoder, display control and
// test latches, channel-select state machine with scan test, tone enable
// and the three-switch channel tree.
// Assumes all inputs synchronous to clock_in; drives are pre-squared.
//
// Local design decisions: the register addresses and the plain strobed port.
`default_nettype none
module display_channel_sequencer
   import display_seq_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int TONE_HALF = TONE_HALF_CYCLES
) (
   // Clock, reset, clock enable
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic enable_in,
   // Processor port
   input wire logic [ADDR_W-1:0] bus_addr_in,
   input wire logic [DATA_W-1:0] bus_wdata_in,
   input wire logic qualified_write_in,
   input wire logic bus_read_in,
   output logic [DATA_W-1:0] bus_rdata_out,
   output logic [NUM_STROBES-1:0] write_strobe_n_out,
   // Mainframe drives
   input wire logic chop_drive_in,
   input wire logic alt_drive_in,
   // Channel selects
   output logic [3:0] channel_select_n_out,
   output logic trigger_view_select_n_out,
   // Test latch outputs
   output logic scan_readback_bit_out,
   output logic speaker_out,
   output logic led_mode_out,
   output logic probe_offset_green_drive_n_out,
   output logic probe_offset_red_drive_n_out,
   // Signal path
   input wire logic [WIDTH-1:0] ch1_in,
   input wire logic [WIDTH-1:0] ch2_in,
   input wire logic [WIDTH-1:0] ch3_in,
   input wire logic [WIDTH-1:0] ch4_in,
   input wire logic [WIDTH-1:0] trigger_view_in,
   output logic [WIDTH-1:0] trace_out
);
   typedef enum logic [1:0] {
      MODE_RUN = 2'b01,
      MODE_SCAN = 2'b10
   } seq_mode_type;

   logic [DATA_W-1:0] control_latch;
   logic [DATA_W-1:0] test_latch;
   logic [NUM_SELECTS-1:0] position;
   logic drive_prev;
   logic scan_clk_prev;
   logic init_done;
   seq_mode_type mode;

   // Strobe decode
   wire logic [NUM_STROBES-1:0] strobe_hot =
      qualified_write_in ? (NUM_STROBES'(1) << bus_addr_in) : '0;
   wire logic control_write = strobe_hot[STROBE_CONTROL];
   wire logic test_write = strobe_hot[STROBE_TEST];

   assign write_strobe_n_out = ~strobe_hot;

   // Sequencer inputs
   wire logic [NUM_SELECTS-1:0] display_enable = control_latch[NUM_SELECTS-1:0];
   wire logic drive_alt = control_latch[CTRL_DRIVE_ALT_BIT];
   wire logic drive_now = drive_alt ? alt_drive_in : chop_drive_in;
   wire logic drive_edge = drive_now ^ drive_prev;
   wire logic scan_on = test_latch[TEST_SCAN_MODE_BIT];
   wire logic scan_clk = test_latch[TEST_SCAN_CLK_BIT];
   wire logic scan_rise = scan_clk & ~scan_clk_prev;
   wire logic scan_data = control_latch[0];
   wire seq_mode_type next_mode = scan_on ? MODE_SCAN : MODE_RUN;

   function automatic logic [NUM_SELECTS-1:0] next_pick(
      input logic [NUM_SELECTS-1:0] cur,
      input logic [NUM_SELECTS-1:0] en
   );
      logic [NUM_SELECTS-1:0] res;
      logic found;
      int start;
      int j;
      res = '0;
      found = 1'b0;
      start = 0;
      j = 0;
      for (int i = 0; i < NUM_SELECTS; i++) begin
         if (cur[i]) begin
            start = i + 1;
         end
      end
      for (int k = 0; k < NUM_SELECTS; k++) begin
         j = (start + k) % NUM_SELECTS;
         if (!found && en[j]) begin
            res[j] = 1'b1;
            found = 1'b1;
         end
      end
      return res;
   endfunction : next_pick

   wire logic [NUM_SELECTS-1:0] next_position_run = next_pick(position, display_enable);
   wire logic [NUM_SELECTS-1:0] next_position_scan =
      {position[NUM_SELECTS-2:0], scan_data};

   logic [NUM_SELECTS-1:0] next_position;
   always_comb begin
      next_position = position;
      case (mode)
         MODE_RUN: begin
            if (drive_edge) begin
               next_position = next_position_run;
            end
         end
         MODE_SCAN: begin
            if (scan_rise) begin
               next_position = next_position_scan;
            end
         end
         default: begin
            next_position = '0;
         end
      endcase
   end

   // Latches and state
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         control_latch <= CTRL_RESET;
         test_latch <= TEST_RESET;
      end else if (enable_in) begin
         if (control_write) begin
            control_latch <= bus_wdata_in;
         end
         if (test_write) begin
            test_latch <= bus_wdata_in;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         position <= '0;
         drive_prev <= 1'b0;
         scan_clk_prev <= 1'b0;
         mode <= MODE_RUN;
      end else if (enable_in) begin
         position <= next_position;
         drive_prev <= drive_now;
         scan_clk_prev <= scan_clk;
         mode <= next_mode;
      end
   end

   // First write to the test latch marks the end of start-up
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         init_done <= 1'b0;
      end else if (enable_in && test_write) begin
         init_done <= 1'b1;
      end
   end

   // Selects: masked by the enables and blanked in scan mode, so a shifted
   // pattern never puts two channels on screen at once
   // A shifted chain can leave several position bits set, so only the lowest is shown
   wire logic [NUM_SELECTS-1:0] select_masked = position & display_enable;
   wire logic [NUM_SELECTS-1:0] select_lowest = select_masked & (~select_masked + NUM_SELECTS'(1));
   wire logic [NUM_SELECTS-1:0] select_hot = (mode == MODE_RUN) ? select_lowest : '0;
   wire logic [NUM_SELECTS-1:0] select_n = ~select_hot;

   assign channel_select_n_out = select_n[3:0];
   assign trigger_view_select_n_out = select_n[4];
   assign scan_readback_bit_out = (mode == MODE_SCAN) & position[NUM_SELECTS-1];
   assign led_mode_out = test_latch[TEST_LED_MODE_BIT];
   assign probe_offset_green_drive_n_out = test_latch[TEST_GREEN_BIT];
   assign probe_offset_red_drive_n_out = test_latch[TEST_RED_BIT];

   // Readback
   wire logic [DATA_W-1:0] status_word = {1'b0, init_done, scan_readback_bit_out, position};
   wire logic [DATA_W-1:0] next_rdata =
      !bus_read_in ? '0 :
      (bus_addr_in == STROBE_CONTROL) ? control_latch :
      (bus_addr_in == STROBE_TEST) ? test_latch :
      (bus_addr_in == READ_STATUS) ? status_word : '0;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         bus_rdata_out <= '0;
      end else if (enable_in) begin
         bus_rdata_out <= next_rdata;
      end
   end

   // Tone
   wire logic speaker_run = init_done & test_latch[TEST_SPEAKER_BIT];

   tone_gen #(
      .HALF_CYCLES(TONE_HALF)
   ) u_tone (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .enable_in(enable_in),
      .run_in(speaker_run),
      .tone_out(speaker_out)
   );

   // Switch tree; the final switch adds one cycle behind the pair switches
   wire logic [SWITCH_INPUTS-1:0] pair12_sel_n = {2'b11, select_n[1], select_n[0]};
   wire logic [SWITCH_INPUTS-1:0] pair34_sel_n = {2'b11, select_n[3], select_n[2]};
   wire logic [SWITCH_INPUTS-1:0] merge_sel_n =
      {~(select_hot[2] | select_hot[3]), ~(select_hot[0] | select_hot[1]), select_n[4], 1'b1};
   logic [WIDTH-1:0] pair12_out;
   logic [WIDTH-1:0] pair34_out;
   logic [WIDTH-1:0] tv_delayed;

   // Trigger view waits one cycle to line up with the pair outputs
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         tv_delayed <= '0;
      end else if (enable_in) begin
         tv_delayed <= trigger_view_in;
      end
   end

   logic [SWITCH_INPUTS-1:0] merge_sel_q;
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         merge_sel_q <= 4'hF;
      end else if (enable_in) begin
         merge_sel_q <= merge_sel_n;
      end
   end

   chan_switch #(
      .WIDTH(WIDTH)
   ) u_pair12 (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .enable_in(enable_in),
      .in_a_in(ch1_in),
      .in_b_in(ch2_in),
      .in_c_in('0),
      .in_d_in('0),
      .select_n_in(pair12_sel_n),
      .out_out(pair12_out)
   );

   chan_switch #(
      .WIDTH(WIDTH)
   ) u_pair34 (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .enable_in(enable_in),
      .in_a_in(ch3_in),
      .in_b_in(ch4_in),
      .in_c_in('0),
      .in_d_in('0),
      .select_n_in(pair34_sel_n),
      .out_out(pair34_out)
   );

   chan_switch #(
      .WIDTH(WIDTH)
   ) u_merge (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .enable_in(enable_in),
      .in_a_in('0),
      .in_b_in(tv_delayed),
      .in_c_in(pair12_out),
      .in_d_in(pair34_out),
      .select_n_in(merge_sel_q),
      .out_out(trace_out)
   );

   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   a_strobe_decode: assert property (
      qualified_write_in |-> (write_strobe_n_out == ~(NUM_STROBES'(1) << bus_addr_in)))
      else $error("write strobe decode wrong");

   a_strobe_width: assert property (
      (write_strobe_n_out != 8'hFF) |-> qualified_write_in ##1 (!qualified_write_in ->
         write_strobe_n_out == 8'hFF))
      else $error("write strobe outlasts write pulse");

   a_select_exclusive: assert property (
      $onehot0(~{trigger_view_select_n_out, channel_select_n_out}))
      else $error("more than one select asserted");

   a_no_display_idle: assert property (
      (control_latch[4:0] == 5'h00) |-> ({trigger_view_select_n_out, channel_select_n_out} == 5'h1F))
      else $error("select asserted with nothing enabled");

   a_advance_edge: assert property (
      (enable_in && mode == MODE_RUN && drive_edge && !control_write && $countones(display_enable) > 1
         && (position & display_enable) != 5'h00) |=> (position != $past(position)))
      else $error("sequencer missed a drive edge");

   a_scan_shift: assert property (
      (enable_in && mode == MODE_SCAN && scan_rise) |=>
         (position == {$past(position[3:0]), $past(control_latch[0])}))
      else $error("scan chain shift wrong");

   a_scan_readback: assert property (
      (mode == MODE_SCAN) |-> (scan_readback_bit_out == position[4]))
      else $error("readback bit not the chain output");

   a_test_latch_out: assert property (
      (enable_in && test_write) |=> (led_mode_out == $past(bus_wdata_in[3]) &&
         probe_offset_green_drive_n_out == $past(bus_wdata_in[4])))
      else $error("test latch outputs not loaded");

   a_speaker_quiet: assert property (
      (!init_done && enable_in) |=> !speaker_out)
      else $error("speaker sounded before init");

   a_tone_stopped: assert property (
      (!speaker_run && enable_in) |=> !speaker_out)
      else $error("tone runs while disabled");

endmodule : display_channel_sequencer
`default_nettype wire

// *** mainframe_drive.sv ***
// Mainframe model: chop and alternate drive levels for the sequencer.
// Assumes toggle requests are one-cycle pulses synchronous to clock_in.
`default_nettype none
module mainframe_drive (
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Requests from the bench
   input wire logic toggle_chop_in,
   input wire logic toggle_alt_in,
   // Drives
   output logic chop_drive_out,
   output logic alt_drive_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each request flips a level, so rising and falling edges both occur
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         chop_drive_out <= 1'b0;
         alt_drive_out <= 1'b0;
      end else begin
         if (toggle_chop_in) chop_drive_out <= ~chop_drive_out;
         if (toggle_alt_in) alt_drive_out <= ~alt_drive_out;
      end
   end
endmodule : mainframe_drive
`default_nettype wire

// *** display_channel_sequencer_tb.sv ***
// Self-checking bench for the display channel sequencer.
// Assumes TONE_HALF of 4 and a mainframe_drive model for the drives.
`default_nettype none
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module display_channel_sequencer_tb;
   import display_seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [2:0] bus_addr_in = 3'h0;
   logic [7:0] bus_wdata_in = 8'h00;
   logic qualified_write_in = 1'b0;
   logic bus_read_in = 1'b0;
   logic enable_in = 1'b1;
   logic tog_chop = 1'b0;
   logic tog_alt = 1'b0;
   logic [7:0] ch_data [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
   logic [7:0] bus_rdata_out, write_strobe_n_out, trace_out, rd;
   logic [3:0] channel_select_n_out;
   logic trigger_view_select_n_out, scan_readback_bit_out, speaker_out, led_mode_out;
   logic green_n, red_n, chop, alt;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   initial forever #5 clock_in = ~clock_in;
   mainframe_drive partner_u (.clock_in(clock_in), .nrst_in(nrst_in), .toggle_chop_in(tog_chop),
      .toggle_alt_in(tog_alt), .chop_drive_out(chop), .alt_drive_out(alt));
   display_channel_sequencer #(.WIDTH(8), .TONE_HALF(4)) dut_u (.clock_in(clock_in), .nrst_in(nrst_in),
      .enable_in(enable_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
      .qualified_write_in(qualified_write_in), .bus_read_in(bus_read_in), .bus_rdata_out(bus_rdata_out),
      .write_strobe_n_out(write_strobe_n_out), .chop_drive_in(chop), .alt_drive_in(alt),
      .channel_select_n_out(channel_select_n_out), .trigger_view_select_n_out(trigger_view_select_n_out),
      .scan_readback_bit_out(scan_readback_bit_out), .speaker_out(speaker_out), .led_mode_out(led_mode_out),
      .probe_offset_green_drive_n_out(green_n), .probe_offset_red_drive_n_out(red_n),
      .ch1_in(ch_data[0]), .ch2_in(ch_data[1]), .ch3_in(ch_data[2]), .ch4_in(ch_data[3]),
      .trigger_view_in(ch_data[4]), .trace_out(trace_out));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   // Hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end
   task automatic idle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : idle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_in);
      bus_addr_in <= a;
      bus_wdata_in <= d;
      qualified_write_in <= 1'b1;
      @(posedge clock_in);
      qualified_write_in <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock_in);
      bus_addr_in <= a;
      bus_read_in <= 1'b1;
      @(posedge clock_in);
      bus_read_in <= 1'b0;
      #1;
      d = bus_rdata_out;
   endtask : rdr
   // Toggle one drive, then check the select and, three cycles on, the trace
   task automatic step(input logic use_alt, input int idx);
      @(posedge clock_in);
      if (use_alt) tog_alt <= 1'b1;
      else tog_chop <= 1'b1;
      @(posedge clock_in);
      tog_alt <= 1'b0;
      tog_chop <= 1'b0;
      idle(3);
      `CHECK("selects", (idx == 5) ? 5'h1F : ~(5'h01 << idx), {trigger_view_select_n_out, channel_select_n_out})
      idle(3);
      `CHECK("trace", (idx == 5) ? 8'h00 : ch_data[idx], trace_out)
   endtask : step
   task automatic t_reset();
      `CHECK("idle selects", 5'h1F, {trigger_view_select_n_out, channel_select_n_out})
      `CHECK("test outs", 4'h3, {speaker_out, led_mode_out, green_n, red_n})
      rdr(READ_STATUS, rd);
      `CHECK("init flag", 1'b0, rd[STAT_INIT_BIT])
      `CHECK("speaker", 1'b0, speaker_out)
      rdr(3'h5, rd);
      `CHECK("unmapped read", 8'h00, rd)
      $display("done reset");
   endtask : t_reset
   task automatic t_strobes();
      for (int a = 0; a < 8; a++) begin
         @(posedge clock_in);
         bus_addr_in <= 3'(a);
         bus_wdata_in <= (a == 1) ? TEST_RESET : 8'h00;
         qualified_write_in <= 1'b1;
         #1;
         `CHECK("strobe", ~(8'h01 << a), write_strobe_n_out)
      end
      // A held write keeps its strobe low for the whole pulse
      for (int i = 0; i < WRITE_PULSE_CYCLES; i++) begin
         @(posedge clock_in);
         bus_addr_in <= 3'h2;
         #1;
         if (i > 0) `CHECK("held strobe", 8'hFB, write_strobe_n_out)
      end
      @(posedge clock_in);
      qualified_write_in <= 1'b0;
      #1;
      `CHECK("strobe end", 8'hFF, write_strobe_n_out)
      $display("done strobes");
   endtask : t_strobes
   task automatic t_sequence();
      wr(STROBE_CONTROL, 8'h15);
      idle(2);
      `CHECK("no position", 5'h1F, {trigger_view_select_n_out, channel_select_n_out})
      step(1'b0, 0);
      step(1'b0, 2);
      step(1'b0, 4);
      step(1'b0, 0);
      // Switch to the alternate drive while both levels agree
      wr(STROBE_CONTROL, 8'h25);
      idle(2);
      step(1'b1, 2);
      step(1'b1, 0);
      step(1'b0, 0);
      // Chop is high and alternate low here, so the drive change itself advances to channel 2
      wr(STROBE_CONTROL, 8'h0A);
      idle(2);
      `CHECK("drive change", 5'h1D, {trigger_view_select_n_out, channel_select_n_out})
      step(1'b0, 3);
      step(1'b0, 1);
      wr(STROBE_CONTROL, 8'h00);
      idle(2);
      step(1'b0, 5);
      $display("done sequence");
   endtask : t_sequence
   // With the enable low a drive edge is held back and lands once the enable returns
   task automatic t_freeze();
      wr(STROBE_CONTROL, 8'h03);
      idle(2);
      @(posedge clock_in);
      enable_in <= 1'b0;
      tog_chop <= 1'b1;
      @(posedge clock_in);
      tog_chop <= 1'b0;
      idle(3);
      `CHECK("frozen selects", 5'h1F, {trigger_view_select_n_out, channel_select_n_out})
      @(posedge clock_in);
      enable_in <= 1'b1;
      idle(3);
      `CHECK("thawed selects", 5'h1E, {trigger_view_select_n_out, channel_select_n_out})
      $display("done freeze");
   endtask : t_freeze
   task automatic t_scan();
      logic [7:0] pat;
      pat = 8'hB2;
      wr(STROBE_TEST, 8'h32);
      for (int i = 0; i < 8; i++) begin
         wr(STROBE_CONTROL, {7'h00, pat[i]});
         wr(STROBE_TEST, 8'h33);
         wr(STROBE_TEST, 8'h32);
         idle(2);
         `CHECK("scan selects", 5'h1F, {trigger_view_select_n_out, channel_select_n_out})
         if (i >= 4) `CHECK("readback", pat[i-4], scan_readback_bit_out)
      end
      rdr(READ_STATUS, rd);
      `CHECK("status readback", pat[3], rd[STAT_READBACK_BIT])
      `CHECK("status chain", 5'h0D, rd[4:0])
      wr(STROBE_TEST, 8'h30);
      idle(2);
      `CHECK("readback off", 1'b0, scan_readback_bit_out)
      // The chain leaves several position bits set; still only one select may show
      wr(STROBE_CONTROL, 8'h1F);
      idle(2);
      `CHECK("one select after scan", 5'h1E, {trigger_view_select_n_out, channel_select_n_out})
      $display("done scan");
   endtask : t_scan
   task automatic t_test_latch();
      int n;
      wr(STROBE_TEST, 8'h08);
      idle(2);
      `CHECK("test outs", 4'h4, {speaker_out, led_mode_out, green_n, red_n})
      rdr(READ_STATUS, rd);
      `CHECK("init flag", 1'b1, rd[STAT_INIT_BIT])
      wr(STROBE_TEST, 8'h34);
      idle(3);
      n = 0;
      for (int i = 0; i < 40; i++) begin
         rd[0] = speaker_out;
         idle(1);
         if (speaker_out !== rd[0]) n++;
      end
      `CHECK("tone edges", 10, n)
      wr(STROBE_TEST, 8'h30);
      idle(2);
      n = 0;
      for (int i = 0; i < 20; i++) begin
         idle(1);
         if (speaker_out !== 1'b0) n++;
      end
      `CHECK("tone stopped", 0, n)
      $display("done test latch");
   endtask : t_test_latch
   initial begin
      repeat (4) @(posedge clock_in);
      nrst_in <= 1'b1;
      idle(1);
      t_reset();
      t_strobes();
      t_sequence();
      t_freeze();
      t_scan();
      t_test_latch();
      final_report();
   end
endmodule : display_channel_sequencer_tb
`undef CHECK
`default_nettype wire
